/* inc/lfw_pkg.sv */
// shared constants, types and register map of the lf wake-up receiver fsm
package lfw_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_FLAGS = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_ON = 8'h14;
  localparam logic [7:0] A_OFF = 8'h18;
  localparam logic [7:0] A_DUR = 8'h1C;
  localparam logic [7:0] A_PAT = 8'h20;
  localparam logic [7:0] A_PTO = 8'h24;
  localparam logic [7:0] A_BUFF = 8'h28;
  localparam logic [2:0] A_DATA_HI = 3'h2;
  localparam int NBUF = 7;
  localparam int NFLAG = 6;
  localparam int F_CAR = 0;
  localparam int F_SYNC = 1;
  localparam int F_PAT = 2;
  localparam int F_EOM = 3;
  localparam int F_BUF = 4;
  localparam int F_CV = 5;
  localparam logic [15:0] ON_RST = 16'h03E8;
  localparam logic [15:0] OFF_RST = 16'h0FA0;
  localparam logic [15:0] DUR_RST = 16'h0064;
  localparam logic [15:0] PTO_RST = 16'h1000;
  localparam logic [15:0] PAT_RST = 16'h0000;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [3:0] THR_RST = 4'h1;
  localparam logic [4:0] BITS_P8 = 5'h07;
  localparam logic [4:0] BITS_P16 = 5'h0F;

  typedef enum logic [1:0] {
    MODE_CW = 2'h0,
    MODE_DR = 2'h1,
    MODE_TG = 2'h2
  } lfw_mode_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_INIT = 4'h1,
    ST_CW_AMP = 4'h2,
    ST_CW_DUR = 4'h3,
    ST_CW_WAIT = 4'h4,
    ST_CW_IDLE = 4'h5,
    ST_SYNC = 4'h6,
    ST_PAT = 4'h7,
    ST_DATA = 4'h8,
    ST_WAIT_INIT = 4'h9
  } lfw_state_t;

  typedef struct packed {
    lfw_mode_t rx_mode_select;
    logic fsm_reinit;
    logic onoff_timer_enable;
    logic receiver_enable;
  } lfw_ctrl_t;

  typedef struct packed {
    logic bufwake_en;
    logic pat16;
    logic pat_req;
    logic [2:0] buffer_wake_address;
    logic [3:0] carrier_count_threshold;
  } lfw_cfg_t;

  typedef struct packed {
    logic sync_hit;
    logic code_viol;
    logic bit_valid;
    logic bit_data;
  } lfw_dec_t;
endpackage

/* core/lfw_sync3.sv */
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module lfw_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule

/* core/lfw_ring.sv */
// ring data buffer with pending and overwrite flags per entry
`timescale 1ns/1ps
module lfw_ring #(
  parameter int N = 7,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [2:0] rd_idx,
  input wire logic [N-1:0] ovw_clr,
  output logic [2:0] wr_ptr,
  output logic [W-1:0] rd_q,
  output logic [N-1:0] pend,
  output logic [N-1:0] ovw
);
  logic [W-1:0] mem [N];
  logic [N-1:0] wr_set;
  logic [N-1:0] rd_clr;

  assign wr_set = wr_en ? (N'(1) << wr_ptr) : '0;
  assign rd_clr = rd_en ? (N'(1) << rd_idx) : '0;
  assign rd_q = (32'(rd_idx) < N) ? mem[rd_idx] : '0;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 3'h0;
      pend <= '0;
      ovw <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr <= (32'(wr_ptr) == N - 1) ? 3'h0 : wr_ptr + 3'h1;
      end
      pend <= (pend & ~rd_clr) | wr_set;
      ovw <= (ovw & ~ovw_clr) | (wr_set & pend);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ring_wrap_ptr: assert property (
    wr_en && 32'(wr_ptr) == N - 1 |=> wr_ptr == 3'h0 ##0 pend[N-1])
    else $error("ring pointer did not wrap");
endmodule

/* core/lfw_fsm.sv */
// lf wake-up receiver control fsm with ahb-lite register slave
//
// Contract
// - mode field picks carrier, data or toggle
// - enable and timer phase gate receiver on
// - first enable initialises the fsm automatically
// - after some wakes wait for reinit
// - reinit bit self-clears after initialisation
// - timer off phase performs reinit automatically
// - data-mode wakes clear timer enable bit
// - amplitude then duration check, restart on fail
// - on-time expiry clears counter, back idle
// - counter meets threshold raises carrier wake
// - below threshold receiver off until on-end
// - sync mandatory, other criteria optional
// - sync search ends on-end, sync persists
// - pattern timeout or violation returns sync
// - pattern match wakes, then receive data
// - seven byte ring buffer wraps around
// - violation ends data, eom wake, wait
// - masked eom with on-time resumes sync
// - buffer address write raises buffer wake
// - status flag reports code violation
// - toggle mode alternates with own sensitivity
// - baseband logic runs on one clock
// - per entry pending and overwrite flags
`timescale 1ns/1ps
module lfw_fsm (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic carrier_amp_pin,
  input wire lfw_pkg::lfw_dec_t dec,
  output logic rx_active,
  output logic sens_sel,
  output logic wake
);
  import lfw_pkg::*;

  lfw_ctrl_t ctrl_r;
  lfw_cfg_t cfg_r;
  logic [NFLAG-1:0] mask_r;
  logic [NFLAG-1:0] flags_r;
  logic [NFLAG-1:0] fset;
  logic [15:0] on_len_r;
  logic [15:0] off_len_r;
  logic [15:0] dur_min_r;
  logic [15:0] pat_r;
  logic [15:0] pto_r;
  logic [15:0] tim_cnt_r;
  logic [15:0] dur_cnt_r;
  logic [15:0] pto_cnt_r;
  logic [15:0] shf_r;
  logic [4:0] bcnt_r;
  logic [3:0] cdc_r;
  logic [3:0] cdc_nxt;
  logic on_phase_r;
  logic tog_r;
  logic rx_en_q_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  lfw_state_t st_r;
  lfw_state_t st_nxt;
  logic clr_tim;
  logic ring_wr;
  logic amp_ok;
  logic [2:0] wr_ptr;
  logic [7:0] ring_q;
  logic [NBUF-1:0] pend;
  logic [NBUF-1:0] ovw;
  logic [31:0] rd_mux;

  lfw_sync3 u_amp_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(carrier_amp_pin),
    .q(amp_ok)
  );

  // bus decode
  wire acc = hsel & hready & htrans[1] & (hsize == 3'h2);
  wire rd_acc = acc & ~hwrite;
  wire [7:0] ra = haddr[7:0];
  wire data_hit = (ra[7:5] == A_DATA_HI) & (ra[4:2] != 3'h7);
  wire we_ctrl = wr_pend_r & (wr_addr_r == A_CTRL);
  wire we_cfg = wr_pend_r & (wr_addr_r == A_CFG);
  wire we_mask = wr_pend_r & (wr_addr_r == A_MASK);
  wire we_flags = wr_pend_r & (wr_addr_r == A_FLAGS);
  wire we_on = wr_pend_r & (wr_addr_r == A_ON);
  wire we_off = wr_pend_r & (wr_addr_r == A_OFF);
  wire we_dur = wr_pend_r & (wr_addr_r == A_DUR);
  wire we_pat = wr_pend_r & (wr_addr_r == A_PAT);
  wire we_pto = wr_pend_r & (wr_addr_r == A_PTO);
  wire we_buff = wr_pend_r & (wr_addr_r == A_BUFF);
  wire [NFLAG-1:0] fclr = we_flags ? hwdata[NFLAG-1:0] : '0;
  wire [NBUF-1:0] oclr = we_buff ? hwdata[14:8] : '0;

  assign rd_mux = data_hit ? {24'h0, ring_q} :
    (ra == A_CTRL) ? {27'h0, ctrl_r} :
    (ra == A_CFG) ? {22'h0, cfg_r} :
    (ra == A_MASK) ? {26'h0, mask_r} :
    (ra == A_FLAGS) ? {26'h0, flags_r} :
    (ra == A_STAT) ? {21'h0, on_phase_r, tog_r, rx_active, cdc_r, st_r} :
    (ra == A_ON) ? {16'h0, on_len_r} :
    (ra == A_OFF) ? {16'h0, off_len_r} :
    (ra == A_DUR) ? {16'h0, dur_min_r} :
    (ra == A_PAT) ? {16'h0, pat_r} :
    (ra == A_PTO) ? {16'h0, pto_r} :
    (ra == A_BUFF) ? {17'h0, ovw, 1'b0, pend} : 32'h0;

  // on-off timer and activation
  wire tim_use = ctrl_r.receiver_enable & ctrl_r.onoff_timer_enable;
  wire on_end = tim_use & on_phase_r & (tim_cnt_r >= on_len_r - 16'h1);
  wire off_end = tim_use & ~on_phase_r & (tim_cnt_r >= off_len_r - 16'h1);
  wire active = ctrl_r.receiver_enable & (~ctrl_r.onoff_timer_enable | on_phase_r);
  wire drm_sel = (ctrl_r.rx_mode_select == MODE_DR) |
    ((ctrl_r.rx_mode_select == MODE_TG) & tog_r);
  wire init_req = (st_r != ST_INIT) & (ctrl_r.fsm_reinit |
    (ctrl_r.receiver_enable & ~rx_en_q_r) |
    (tim_use & ~on_phase_r & (st_r == ST_WAIT_INIT)));

  // bit level helpers
  wire [15:0] shf_in = {shf_r[14:0], dec.bit_data};
  wire [4:0] pat_last = cfg_r.pat16 ? BITS_P16 : BITS_P8;
  wire pat_done = dec.bit_valid & (bcnt_r == pat_last);
  wire pat_hit = cfg_r.pat16 ? (shf_in == pat_r) : (shf_in[7:0] == pat_r[7:0]);
  wire byte_done = dec.bit_valid & (bcnt_r[2:0] == 3'h7);
  wire pto_hit = pto_cnt_r >= pto_r;
  wire dur_ok = dur_cnt_r >= dur_min_r;
  wire [3:0] cdc_inc = cdc_r + 4'h1;
  wire cdc_met = cdc_inc >= cfg_r.carrier_count_threshold;
  wire new_st = st_nxt != st_r;
  wire act_nxt = (st_nxt != ST_OFF) & (st_nxt != ST_INIT) &
    (st_nxt != ST_CW_IDLE) & (st_nxt != ST_WAIT_INIT);

  always_comb begin
    st_nxt = st_r;
    fset = '0;
    cdc_nxt = cdc_r;
    clr_tim = 1'b0;
    ring_wr = 1'b0;
    case (st_r)
      ST_OFF: begin
        if (active) begin
          st_nxt = drm_sel ? ST_SYNC : ST_CW_AMP;
        end
      end
      ST_INIT: begin
        st_nxt = ST_OFF;
        cdc_nxt = 4'h0;
      end
      ST_CW_AMP: begin
        if (on_end) begin
          cdc_nxt = 4'h0;
          st_nxt = ST_OFF;
        end else if (amp_ok) begin
          st_nxt = ST_CW_DUR;
        end
      end
      ST_CW_DUR: begin
        if (on_end) begin
          cdc_nxt = 4'h0;
          st_nxt = ST_OFF;
        end else if (!amp_ok) begin
          st_nxt = ST_CW_AMP;
        end else if (dur_ok) begin
          cdc_nxt = cdc_inc;
          if (cdc_met) begin
            fset[F_CAR] = 1'b1;
            st_nxt = ST_CW_WAIT;
          end else begin
            st_nxt = ST_CW_IDLE;
          end
        end
      end
      ST_CW_WAIT, ST_CW_IDLE: begin
        if (on_end) begin
          st_nxt = ST_OFF;
        end
      end
      ST_SYNC: begin
        if (on_end) begin
          st_nxt = ST_OFF;
        end else if (dec.sync_hit) begin
          fset[F_SYNC] = 1'b1;
          clr_tim = mask_r[F_SYNC];
          st_nxt = cfg_r.pat_req ? ST_PAT : ST_DATA;
        end
      end
      ST_PAT: begin
        if (dec.code_viol || pto_hit) begin
          st_nxt = ST_SYNC;
        end else if (pat_done) begin
          if (pat_hit) begin
            fset[F_PAT] = 1'b1;
            clr_tim = mask_r[F_PAT];
            st_nxt = ctrl_r.receiver_enable ? ST_DATA : ST_WAIT_INIT;
          end else begin
            st_nxt = ST_SYNC;
          end
        end
      end
      ST_DATA: begin
        if (dec.code_viol) begin
          fset[F_CV] = 1'b1;
          fset[F_EOM] = 1'b1;
          if (mask_r[F_EOM]) begin
            clr_tim = 1'b1;
            st_nxt = ST_WAIT_INIT;
          end else begin
            st_nxt = active ? ST_SYNC : ST_OFF;
          end
        end else if (byte_done) begin
          ring_wr = 1'b1;
          if (cfg_r.bufwake_en && wr_ptr == cfg_r.buffer_wake_address) begin
            fset[F_BUF] = 1'b1;
            clr_tim = mask_r[F_BUF];
          end
        end
      end
      ST_WAIT_INIT: begin
        st_nxt = ST_WAIT_INIT;
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
    if (init_req) begin
      st_nxt = ST_INIT;
    end else if (!ctrl_r.receiver_enable) begin
      st_nxt = ST_OFF;
    end
  end

  lfw_ring #(
    .N(NBUF),
    .W(8)
  ) u_ring (
    .clk(hclk),
    .rst_n(hresetn),
    .wr_en(ring_wr),
    .wr_data(shf_in[7:0]),
    .rd_en(rd_acc & data_hit),
    .rd_idx(ra[4:2]),
    .ovw_clr(oclr),
    .wr_ptr(wr_ptr),
    .rd_q(ring_q),
    .pend(pend),
    .ovw(ovw)
  );

  // bus slave, zero wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= ra;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_acc) begin
        hrdata <= rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= '0;
      cfg_r <= '{default: '0, carrier_count_threshold: THR_RST};
      mask_r <= MASK_RST;
      on_len_r <= ON_RST;
      off_len_r <= OFF_RST;
      dur_min_r <= DUR_RST;
      pat_r <= PAT_RST;
      pto_r <= PTO_RST;
    end else begin
      if (we_ctrl) begin
        ctrl_r <= lfw_ctrl_t'(hwdata[4:0]);
      end else begin
        if (clr_tim) begin
          ctrl_r.onoff_timer_enable <= 1'b0;
        end
        if (st_r == ST_INIT) begin
          ctrl_r.fsm_reinit <= 1'b0;
        end
      end
      if (we_cfg) cfg_r <= lfw_cfg_t'(hwdata[9:0]);
      if (we_mask) mask_r <= hwdata[NFLAG-1:0];
      if (we_on) on_len_r <= hwdata[15:0];
      if (we_off) off_len_r <= hwdata[15:0];
      if (we_dur) dur_min_r <= hwdata[15:0];
      if (we_pat) pat_r <= hwdata[15:0];
      if (we_pto) pto_r <= hwdata[15:0];
    end
  end

  // baseband state, all on hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_OFF;
      cdc_r <= 4'h0;
      flags_r <= '0;
      rx_en_q_r <= 1'b0;
      tog_r <= 1'b0;
      rx_active <= 1'b0;
      sens_sel <= 1'b0;
      wake <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cdc_r <= cdc_nxt;
      flags_r <= (flags_r & ~fclr) | fset;
      rx_en_q_r <= ctrl_r.receiver_enable;
      if (st_r == ST_INIT) begin
        tog_r <= 1'b0;
      end else if (on_end && ctrl_r.rx_mode_select == MODE_TG) begin
        tog_r <= ~tog_r;
      end
      rx_active <= act_nxt;
      sens_sel <= drm_sel;
      wake <= |(((flags_r & ~fclr) | fset) & mask_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tim_cnt_r <= 16'h0;
      on_phase_r <= 1'b1;
      dur_cnt_r <= 16'h0;
      pto_cnt_r <= 16'h0;
      shf_r <= 16'h0;
      bcnt_r <= 5'h0;
    end else begin
      if (!tim_use) begin
        tim_cnt_r <= 16'h0;
        on_phase_r <= 1'b1;
      end else if (on_end || off_end) begin
        tim_cnt_r <= 16'h0;
        on_phase_r <= off_end;
      end else begin
        tim_cnt_r <= tim_cnt_r + 16'h1;
      end
      dur_cnt_r <= (new_st || st_r != ST_CW_DUR) ? 16'h0 : dur_cnt_r + 16'h1;
      pto_cnt_r <= (new_st || st_r != ST_PAT) ? 16'h0 : pto_cnt_r + 16'h1;
      if (new_st) begin
        bcnt_r <= 5'h0;
        shf_r <= 16'h0;
      end else if (dec.bit_valid) begin
        bcnt_r <= bcnt_r + 5'h1;
        shf_r <= shf_in;
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_run;
    !init_req && ctrl_r.receiver_enable;
  endsequence
  sequence s_cw_pass;
    st_r == ST_CW_DUR && !on_end && amp_ok && dur_ok ##0 s_run;
  endsequence
  sequence s_eom_hit;
    st_r == ST_DATA && dec.code_viol && mask_r[F_EOM] ##0 s_run;
  endsequence

  a_cw_wake_hit: assert property (
    s_cw_pass ##0 cdc_met |=> st_r == ST_CW_WAIT && flags_r[F_CAR] && cdc_r != 4'h0)
    else $error("carrier wake not raised");
  a_cw_idle_off: assert property (
    s_cw_pass ##0 !cdc_met |=> st_r == ST_CW_IDLE && !rx_active)
    else $error("receiver not idled below threshold");
  a_cw_on_expiry: assert property (
    (st_r == ST_CW_AMP || st_r == ST_CW_DUR) && on_end ##0 s_run
    |=> st_r == ST_OFF && cdc_r == 4'h0)
    else $error("counter not cleared on on-time expiry");
  a_rx_disabled: assert property (
    !ctrl_r.receiver_enable && !init_req |=> st_r == ST_OFF ##1 !rx_active)
    else $error("receiver active while disabled");
  a_init_on_enable: assert property (
    $rose(ctrl_r.receiver_enable) && st_r != ST_INIT |=> st_r == ST_INIT ##1 st_r == ST_OFF)
    else $error("no initialisation on first enable");
  a_reinit_selfclr: assert property (
    st_r == ST_INIT && !we_ctrl |=> !ctrl_r.fsm_reinit)
    else $error("reinit bit not cleared");
  a_timer_cleared: assert property (
    clr_tim && !we_ctrl |=> !ctrl_r.onoff_timer_enable)
    else $error("timer enable kept after data wake");
  a_eom_wait: assert property (
    s_eom_hit |=> st_r == ST_WAIT_INIT && flags_r[F_EOM] && flags_r[F_CV])
    else $error("end of message not handled");
  a_sync_persist: assert property (
    st_r == ST_SYNC && dec.sync_hit && !on_end ##0 s_run
    |=> flags_r[F_SYNC] && (st_r == ST_PAT || st_r == ST_DATA))
    else $error("sync not taken");
  a_flag_sticky: assert property (
    !we_flags |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("wake flag lost without clear");
  a_auto_reinit: assert property (
    st_r == ST_WAIT_INIT && tim_use && !on_phase_r |=> st_r == ST_INIT)
    else $error("no automatic reinit in off phase");
endmodule

/* tb/lfw_tx_model.sv */
// lf transmitter model driving the carrier detector pin and the decoded bit stream
`timescale 1ns/1ps
module lfw_tx_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic hclk,
  output logic carrier_amp,
  output lfw_pkg::lfw_dec_t dec
);
  import lfw_pkg::*;
  initial begin
    carrier_amp = 1'b0;
    dec = '0;
  end
  // between bits the data line keeps flipping so a stale value never looks valid
  task automatic gap(input int n);
    repeat (n) begin
      @(posedge hclk);
      dec <= '{1'b0, 1'b0, 1'b0, ~dec.bit_data};
    end
  endtask
  task automatic set_amp(input logic v);
    @(posedge hclk);
    carrier_amp <= v;
  endtask
  task automatic send_sync();
    @(posedge hclk);
    dec <= '{1'b1, 1'b0, 1'b0, ~dec.bit_data};
    gap(BIT_CYC - 1);
  endtask
  // msb first, one bit every BIT_CYC cycles
  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge hclk);
      dec <= '{1'b0, 1'b0, 1'b1, v[i]};
      gap(BIT_CYC - 1);
    end
  endtask
  task automatic violation();
    @(posedge hclk);
    dec <= '{1'b0, 1'b1, 1'b0, ~dec.bit_data};
    gap(BIT_CYC - 1);
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the lf wake-up receiver fsm
`timescale 1ns/1ps
module testbench;
  import lfw_pkg::*;
  localparam logic [7:0] A_UNMAP = 8'h30;
  localparam logic [7:0] A_BYTE0 = 8'h40;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic amp, rx_active, sens_sel, wake, s0;
  lfw_dec_t dec;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] b [9];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  lfw_fsm dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .carrier_amp_pin(amp), .dec(dec),
    .rx_active(rx_active), .sens_sel(sens_sel), .wake(wake));
  lfw_tx_model tx (.hclk(hclk), .carrier_amp(amp), .dec(dec));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task results();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] ex);
    samples_checked++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  // single transfer of size sz: address phase held until hready, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    exp_q.push_back(ex & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0, 3'h2);
  endtask

  task wait_rx(input logic v);
    do @(negedge hclk); while (rx_active !== v);
  endtask

  task wait_wake(input logic v);
    do @(negedge hclk); while (wake !== v);
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      results();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_ph = 1'b0;
    void'($urandom(79816));
    foreach (b[i]) b[i] = 8'($urandom());
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_CTRL, 32'h0, 32'h1F);
    rd(A_CFG, {28'h0, THR_RST}, 32'h3FF);
    rd(A_MASK, {26'h0, MASK_RST}, 32'hFFFF_FFFF);
    rd(A_FLAGS, 32'h0, 32'hFFFF_FFFF);
    rd(A_ON, {16'h0, ON_RST}, 32'hFFFF_FFFF);
    rd(A_OFF, {16'h0, OFF_RST}, 32'hFFFF_FFFF);
    rd(A_DUR, {16'h0, DUR_RST}, 32'hFFFF_FFFF);
    rd(A_PTO, {16'h0, PTO_RST}, 32'hFFFF_FFFF);
    rd(A_UNMAP, 32'h0, 32'hFFFF_FFFF);
    // carrier detection, timer off, threshold 1
    wr(A_DUR, 32'h8);
    wr(A_MASK, 32'h1);
    wr(A_CTRL, 32'h1);
    repeat (6) @(posedge hclk);
    chk({31'h0, rx_active}, 32'h1);
    tx.set_amp(1'b1);
    repeat (4) @(posedge hclk);
    tx.set_amp(1'b0);
    repeat (12) @(posedge hclk);
    rd(A_FLAGS, 32'h0, 32'h1);
    tx.set_amp(1'b1);
    repeat (40) @(posedge hclk);
    tx.set_amp(1'b0);
    rd(A_FLAGS, 32'h1, 32'h1);
    rd(A_STAT, 32'h14, 32'hFF);
    chk({31'h0, wake}, 32'h1);
    wr(A_FLAGS, 32'h3F);
    rd(A_FLAGS, 32'h0, 32'h3F);
    // two consecutive on periods needed, timer driven
    wr(A_CFG, 32'h2);
    wr(A_ON, 32'hC8);
    wr(A_OFF, 32'h64);
    wr(A_CTRL, 32'h7);
    tx.set_amp(1'b1);
    wait_rx(1'b1);
    wait_rx(1'b0);
    rd(A_STAT, 32'h15, 32'hFF);
    chk({31'h0, wake}, 32'h0);
    wait_wake(1'b1);
    rd(A_STAT, 32'h24, 32'hFF);
    tx.set_amp(1'b0);
    wr(A_FLAGS, 32'h3F);
    repeat (700) @(posedge hclk);
    rd(A_STAT, 32'h0, 32'hF0);
    // data reception, all wakes masked first
    wr(A_CFG, 32'h2A0);
    wr(A_PAT, 32'hA5);
    // a halfword write is ignored, the pattern must survive it
    bus(1'b1, A_PAT, 32'h5A, 3'h1);
    rd(A_PAT, 32'hA5, 32'hFFFF);
    wr(A_PTO, 32'h60);
    wr(A_MASK, 32'h0);
    wr(A_CTRL, 32'hD);
    repeat (6) @(posedge hclk);
    rd(A_CTRL, 32'h9, 32'h1F);
    tx.send_sync();
    tx.send_bits(16'hA, 4);
    tx.violation();
    rd(A_STAT, 32'h6, 32'hF);
    tx.send_sync();
    rd(A_STAT, 32'h7, 32'hF);
    repeat (120) @(posedge hclk);
    rd(A_STAT, 32'h6, 32'hF);
    tx.send_sync();
    tx.send_bits(16'hA5, 8);
    tx.violation();
    rd(A_STAT, 32'h6, 32'hF);
    rd(A_FLAGS, 32'hE, 32'h1F);
    chk({31'h0, wake}, 32'h0);
    wr(A_FLAGS, 32'h3F);
    wr(A_MASK, 32'h1E);
    wr(A_CFG, 32'h3A0);
    wr(A_PAT, 32'h5AC3);
    wr(A_CTRL, 32'hB);
    wait_rx(1'b1);
    tx.send_sync();
    tx.send_bits(16'h5AC3, 16);
    foreach (b[i]) tx.send_bits({8'h0, b[i]}, 8);
    tx.violation();
    rd(A_CTRL, 32'h9, 32'h1F);
    rd(A_STAT, 32'h9, 32'hF);
    rd(A_FLAGS, 32'h3E, 32'h3F);
    chk({31'h0, wake}, 32'h1);
    rd(A_BUFF, 32'h37F, 32'h7F7F);
    rd(A_BYTE0, {24'h0, b[7]}, 32'hFF);
    rd(A_BYTE0 + 8'h4, {24'h0, b[8]}, 32'hFF);
    rd(A_BYTE0 + 8'h8, {24'h0, b[2]}, 32'hFF);
    rd(A_BUFF, 32'h78, 32'h7F);
    wr(A_BUFF, 32'h300);
    rd(A_BUFF, 32'h0, 32'h7F00);
    // toggle mode alternates on successive on periods
    wr(A_FLAGS, 32'h3F);
    wr(A_ON, 32'h64);
    wr(A_OFF, 32'h32);
    // timer back on without reinit: the off phase must reinit from wait-init
    wr(A_CTRL, 32'h3);
    repeat (120) @(posedge hclk);
    rd(A_STAT, 32'h0, 32'hF);
    wr(A_CTRL, 32'h17);
    wait_rx(1'b1);
    s0 = sens_sel;
    wait_rx(1'b0);
    wait_rx(1'b1);
    chk({31'h0, sens_sel}, {31'h0, ~s0});
    wait_rx(1'b0);
    wait_rx(1'b1);
    chk({31'h0, sens_sel}, {31'h0, s0});
    wr(A_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, rx_active}, 32'h0);
    results();
  end
endmodule
